/* src/blfm_cfg.svh */
// Timing counts and constants for the boost LED fault manager.
`ifndef BLFM_CFG_SVH
`define BLFM_CFG_SVH
`define BLFM_CLK_HZ 10000000
`define BLFM_OCP_SHUT_NS 3000
`define BLFM_OCP_SHUT_CYC ((`BLFM_OCP_SHUT_NS * (`BLFM_CLK_HZ / 1000000)) / 1000)
`define BLFM_UVLO_FILT_NS 50000
`define BLFM_UVLO_FILT_CYC ((`BLFM_UVLO_FILT_NS * (`BLFM_CLK_HZ / 1000000) + 999) / 1000)
`define BLFM_RESET_LOW_US 16000
`define BLFM_RESET_LOW_CYC (`BLFM_RESET_LOW_US * (`BLFM_CLK_HZ / 1000000))
`define BLFM_STARTUP_MASK_CYC 1000
`endif

/* src/blfm_pkg.sv */
// Types for the boost LED fault manager.
package blfm_pkg;
  typedef enum logic [1:0] {
    BLFM_OFF = 2'b00,
    BLFM_START = 2'b01,
    BLFM_RUN = 2'b11,
    BLFM_LATCHED = 2'b10
  } blfm_state_e;
endpackage

/* src/blfm_low_timer.sv */
// Counter that reports when a level has been low for a full interval.
`timescale 1ns/1ps
module blfm_low_timer #(
  parameter int COUNT = 16
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // Watched level
  input wire logic level_in,
  // Interval reached
  output logic expired
);
  localparam int W = $clog2(COUNT + 1);
  localparam logic [W-1:0] LAST = W'(COUNT);
  logic [W-1:0] cnt_reg;
  wire at_end = (cnt_reg == LAST);
  // The count restarts whenever the level is high and saturates at the end.
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
      cnt_reg <= '0;
    else if (level_in)
      cnt_reg <= '0;
    else if (!at_end)
      cnt_reg <= cnt_reg + W'(1);
  end
  assign expired = at_end && !level_in;
endmodule

/* src/blfm_core.sv */
// Fault supervision core driving boost gate, disconnect gate, sinks and fault pin.
// Operation
// R1: A secondary switch current trip shuts the device down at once and latches it off.
// R2: An input overcurrent trip completes shutdown well within three microseconds.
// R3: An input overcurrent trip raises the fault indication and latches off until a valid reset.
// R4: An input overcurrent trip drops the disconnect gate immediately, also during startup.
// R5: Operation is enabled above the rising undervoltage level and disabled after 50 us below.
// R6: Selected checks are masked during startup to avoid false fault detection; here no check is masked, the window only delays the move to run.
// R7: A cycle current limit ends the present boost on-time and the next cycle runs normally.
// R8: A cycle current limit blanks the boost for one cycle only, with no fault flag.
// R9: A secondary trip turns off disconnect, sinks and boost, sets the flag, cleared by 16 ms low.
// R10: An input disconnect limit turns all off, sets the flag, cleared by 16 ms enable low.
// R11: An LED pin short at first dimming high halts soft-start with flag set and disconnect on.
// R12: The open-drain fault output is pulled low whenever the fault flag is set.
// R13: An undervoltage lockout clears all latched faults and turns everything off.
// R14: The latch reset counts the low interval on the clock and restarts on enable high.
`timescale 1ns/1ps
`include "blfm_cfg.svh"
module blfm_core #(
  parameter int RESET_LOW_CYC = `BLFM_RESET_LOW_CYC,
  parameter int UVLO_FILT_CYC = `BLFM_UVLO_FILT_CYC,
  parameter int STARTUP_MASK_CYC = `BLFM_STARTUP_MASK_CYC,
  parameter int LED_N = 6
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // Comparator inputs
  input wire logic above_rise_level,
  input wire logic below_fall_level,
  input wire logic cycle_limit_trip,
  input wire logic secondary_trip,
  input wire logic input_overcurrent_trip,
  input wire logic [LED_N-1:0] led_short_gnd,
  // Control inputs
  input wire logic en_pwm,
  input wire logic cycle_start,
  input wire logic softstart_done,
  // Power stage controls
  output logic boost_gate_en,
  output logic disconnect_gate_en,
  output logic sink_en,
  output logic softstart_run,
  // Fault pin, open drain
  output logic fault_out,
  output logic fault_oe_n,
  output logic fault_flag
);
  localparam int UW = $clog2(UVLO_FILT_CYC + 1);
  localparam int MW = $clog2(STARTUP_MASK_CYC + 1);
  localparam logic [UW-1:0] ULAST = UW'(UVLO_FILT_CYC);
  localparam logic [MW-1:0] MLAST = MW'(STARTUP_MASK_CYC);

  blfm_pkg::blfm_state_e state_reg, state_next;
  logic enabled_reg;
  logic [UW-1:0] ucnt_reg;
  logic [MW-1:0] mcnt_reg;
  logic blank_reg;
  logic en_d_reg;
  logic short_reg;
  logic boost_reg, disc_reg, sink_reg, ss_reg, flag_reg, oe_n_reg;
  logic release_low;

  // State decodes shared by the sequencer and the output logic.
  function automatic logic state_is_start(input blfm_pkg::blfm_state_e s);
    state_is_start = (s == blfm_pkg::BLFM_START);
  endfunction

  function automatic logic state_is_live(input blfm_pkg::blfm_state_e s);
    state_is_live = (s == blfm_pkg::BLFM_START) || (s == blfm_pkg::BLFM_RUN);
  endfunction

  // Low interval counter for clearing latched faults.
  blfm_low_timer #(
    .COUNT(RESET_LOW_CYC)
  ) u_low_timer (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .level_in(en_pwm),
    .expired(release_low)
  );

  wire uvlo_hit = below_fall_level && (ucnt_reg == ULAST);
  wire mask_done = (mcnt_reg == MLAST);
  wire latch_trip = secondary_trip || input_overcurrent_trip;
  wire en_rise = en_pwm && !en_d_reg;
  wire any_short = |led_short_gnd;
  wire start_check = state_is_start(state_reg);
  wire short_active = start_check ? (en_rise ? any_short : (short_reg && any_short)) : 1'b0;
  wire live = state_is_live(state_reg);

  // Input glitch filter: disable only after the input stays low long enough.
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
      ucnt_reg <= '0;
    else if (!below_fall_level)
      ucnt_reg <= '0;
    else if (ucnt_reg != ULAST)
      ucnt_reg <= ucnt_reg + UW'(1); // R5
  end

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
      enabled_reg <= 1'b0;
    else if (uvlo_hit)
      enabled_reg <= 1'b0; // R5
    else if (above_rise_level)
      enabled_reg <= 1'b1; // R5
  end

  // Startup mask window; the cycle limit and latched trips are never masked.
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
      mcnt_reg <= '0;
    else if (state_reg != blfm_pkg::BLFM_START)
      mcnt_reg <= '0;
    else if (!mask_done)
      mcnt_reg <= mcnt_reg + MW'(1); // R6
  end

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
      en_d_reg <= 1'b0;
    else
      en_d_reg <= en_pwm;
  end

  // A short found at the first high of dimming holds until it clears.
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
      short_reg <= 1'b0;
    else
      short_reg <= short_active; // R11
  end

  // The cycle blank lasts until the next cycle start, so only one cycle is lost.
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
      blank_reg <= 1'b0;
    else if (cycle_limit_trip)
      blank_reg <= 1'b1; // R7
    else if (cycle_start)
      blank_reg <= 1'b0; // R8
  end

  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      blfm_pkg::BLFM_OFF:
        if (enabled_reg && en_pwm && !uvlo_hit)
          state_next = blfm_pkg::BLFM_START;
      blfm_pkg::BLFM_START:
        if (uvlo_hit || !enabled_reg)
          state_next = blfm_pkg::BLFM_OFF; // R13
        else if (latch_trip)
          state_next = blfm_pkg::BLFM_LATCHED; // R1
        else if (softstart_done && mask_done && !short_active)
          state_next = blfm_pkg::BLFM_RUN;
        else if (release_low)
          state_next = blfm_pkg::BLFM_OFF;
      blfm_pkg::BLFM_RUN:
        if (uvlo_hit || !enabled_reg)
          state_next = blfm_pkg::BLFM_OFF; // R13
        else if (latch_trip)
          state_next = blfm_pkg::BLFM_LATCHED; // R1
        else if (release_low)
          state_next = blfm_pkg::BLFM_OFF;
      blfm_pkg::BLFM_LATCHED:
        if (uvlo_hit || release_low)
          state_next = blfm_pkg::BLFM_OFF; // R14
      default:
        state_next = blfm_pkg::BLFM_OFF;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
      state_reg <= blfm_pkg::BLFM_OFF;
    else
      state_reg <= state_next;
  end

  // The trip inputs also gate the outputs in the same cycle they arrive, so the
  // outputs drop at the first edge after a trip, well within the shutdown budget.
  wire stay_live = live && (state_next != blfm_pkg::BLFM_OFF) && !latch_trip;
  wire boost_next = stay_live && (state_next == state_reg || state_next == blfm_pkg::BLFM_RUN)
                    && !short_active && !cycle_limit_trip && !blank_reg; // R7
  wire disc_next = stay_live; // R4
  wire sink_next = stay_live && !short_active; // R11
  wire ss_next = stay_live && state_is_start(state_reg) && !short_active; // R11
  wire flag_next = (state_next == blfm_pkg::BLFM_LATCHED) || short_active; // R3

  // Each power stage control has its own register so that all of them fall on
  // the same edge as the trip that caused the shutdown.
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
      boost_reg <= 1'b0;
    else
      boost_reg <= boost_next; // R2
  end

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
      disc_reg <= 1'b0;
    else
      disc_reg <= disc_next; // R10
  end

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
      sink_reg <= 1'b0;
    else
      sink_reg <= sink_next; // R9
  end

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
      ss_reg <= 1'b0;
    else
      ss_reg <= ss_next;
  end

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
      flag_reg <= 1'b0;
    else
      flag_reg <= flag_next; // R9
  end

  // The pin enable is built from the same next value as the flag, so the pin
  // and the flag can never disagree for a cycle.
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
      oe_n_reg <= 1'b1;
    else
      oe_n_reg <= !flag_next; // R12
  end

  assign boost_gate_en = boost_reg;
  assign disconnect_gate_en = disc_reg;
  assign sink_en = sink_reg;
  assign softstart_run = ss_reg;
  assign fault_flag = flag_reg;
  assign fault_oe_n = oe_n_reg;
  assign fault_out = 1'b0;
endmodule

/* tb/blfm_core_checker.sv */
// Port assertions for the fault manager core.
`timescale 1ns/1ps
module blfm_core_checker #(
  parameter int RESET_LOW_CYC = 16,
  parameter int UVLO_FILT_CYC = 8,
  parameter int LED_N = 6
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // Inputs watched
  input wire logic below_fall_level,
  input wire logic cycle_limit_trip,
  input wire logic secondary_trip,
  input wire logic input_overcurrent_trip,
  input wire logic [LED_N-1:0] led_short_gnd,
  input wire logic en_pwm,
  // Outputs watched
  input wire logic boost_gate_en,
  input wire logic disconnect_gate_en,
  input wire logic sink_en,
  input wire logic softstart_run,
  input wire logic fault_out,
  input wire logic fault_oe_n,
  input wire logic fault_flag
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rstn);
  // Saturates just past the release interval so the check keeps holding while low.
  int lo_cnt_reg;
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
      lo_cnt_reg <= 0;
    else if (en_pwm)
      lo_cnt_reg <= 0;
    else if (lo_cnt_reg < RESET_LOW_CYC + 2)
      lo_cnt_reg <= lo_cnt_reg + 1;
  end
  // Counts consecutive low input cycles; shutdown is due once the filter is full.
  int fall_cnt_reg;
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
      fall_cnt_reg <= 0;
    else if (!below_fall_level)
      fall_cnt_reg <= 0;
    else if (fall_cnt_reg < UVLO_FILT_CYC)
      fall_cnt_reg <= fall_cnt_reg + 1;
  end
  pin_drive_a: assert property (fault_oe_n != fault_flag && !fault_out)
    else $error("fault pin does not follow the flag");
  sec_latch_a: assert property (secondary_trip && disconnect_gate_en && !fault_flag |=>
    !(boost_gate_en | disconnect_gate_en | sink_en) && fault_flag)
    else $error("secondary trip not latched off");
  ioc_latch_a: assert property (input_overcurrent_trip && disconnect_gate_en && !fault_flag
    |=> !(boost_gate_en | disconnect_gate_en | sink_en) && fault_flag)
    else $error("input overcurrent not latched off");
  limit_cut_a: assert property (cycle_limit_trip && boost_gate_en && !secondary_trip
    && !input_overcurrent_trip |=> !boost_gate_en && !fault_flag && disconnect_gate_en && sink_en)
    else $error("cycle limit response wrong");
  latch_hold_a: assert property (fault_flag && !disconnect_gate_en && en_pwm
    && !below_fall_level |=> fault_flag) else $error("latched fault dropped");
  uvlo_off_a: assert property (below_fall_level && fall_cnt_reg == UVLO_FILT_CYC |=>
    !(disconnect_gate_en | sink_en | fault_flag)) else $error("undervoltage did not shut down");
  short_hold_a: assert property ($rose(en_pwm) && (|led_short_gnd) && disconnect_gate_en
    && softstart_run
    && !fault_flag |=> fault_flag && disconnect_gate_en && !boost_gate_en && !sink_en)
    else $error("pin short response wrong");
  low_release_a: assert property (lo_cnt_reg == RESET_LOW_CYC + 2 |-> !fault_flag)
    else $error("long low enable did not clear the fault");
  cover property (fault_flag && disconnect_gate_en);
  cover property ($fell(disconnect_gate_en) && fault_flag);
  cover property (cycle_limit_trip && boost_gate_en);
endmodule
bind blfm_core blfm_core_checker #(.RESET_LOW_CYC(RESET_LOW_CYC),
  .UVLO_FILT_CYC(UVLO_FILT_CYC), .LED_N(LED_N))
  blfm_core_checker_inst (.*);

/* tb/blfm_partner.sv */
// Model of the switching oscillator, soft-start ramp and pin short comparators.
`timescale 1ns/1ps
module blfm_partner (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // From the core
  input wire logic softstart_run,
  input wire logic disconnect_gate_en,
  // Scenario control
  input wire logic [5:0] short_req,
  // To the core
  output logic cycle_start,
  output logic softstart_done,
  output logic [5:0] led_short_gnd
);
  logic [2:0] osc_reg;
  logic [2:0] ramp_reg;
  assign led_short_gnd = short_req;
  assign cycle_start = (osc_reg == 3'h0);
  assign softstart_done = (ramp_reg == 3'h6);
  // The output collapses when the disconnect opens, so the ramp starts over.
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      osc_reg <= 3'h0;
      ramp_reg <= 3'h0;
    end
    else
    begin
      osc_reg <= (osc_reg == 3'h4) ? 3'h0 : osc_reg + 3'h1;
      if (!disconnect_gate_en)
        ramp_reg <= 3'h0;
      else if (softstart_run && ramp_reg != 3'h6)
        ramp_reg <= ramp_reg + 3'h1;
    end
  end
endmodule

/* tb/blfm_core_tb.sv */
// Self-checking bench for the fault manager core.
`timescale 1ns/1ps
module blfm_core_tb;
  logic clk_sys = 0;
  logic rstn = 0;
  logic rise = 0, fall = 0, lim = 0, sec = 0, ioc = 0, en = 0;
  logic [5:0] short_req = 6'h00;
  logic [5:0] lsg;
  logic cst, ssd, bst, dsc, snk, ssr, fo, foe, ff;
  int err_total = 0;
  int check_count = 0;
  always #50 clk_sys = ~clk_sys;
  blfm_core #(.RESET_LOW_CYC(50), .UVLO_FILT_CYC(8), .STARTUP_MASK_CYC(4)) blfm_core_inst (
    .clk_sys(clk_sys), .rstn(rstn), .above_rise_level(rise), .below_fall_level(fall),
    .cycle_limit_trip(lim), .secondary_trip(sec), .input_overcurrent_trip(ioc),
    .led_short_gnd(lsg), .en_pwm(en), .cycle_start(cst), .softstart_done(ssd),
    .boost_gate_en(bst), .disconnect_gate_en(dsc), .sink_en(snk), .softstart_run(ssr),
    .fault_out(fo), .fault_oe_n(foe), .fault_flag(ff));
  blfm_partner blfm_partner_inst (.clk_sys(clk_sys), .rstn(rstn), .softstart_run(ssr),
    .disconnect_gate_en(dsc), .short_req(short_req), .cycle_start(cst),
    .softstart_done(ssd), .led_short_gnd(lsg));
  task summarize;
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task go(input int n);
    repeat (n) @(negedge clk_sys);
  endtask
  task chk(input string s, input logic e, input logic g);
    check_count++;
    if (g !== e)
    begin
      err_total++;
      $display("mismatch %s expected %b seen %b", s, e, g);
    end
  endtask
  task start_up;
    int i;
    rise = 1;
    en = 1;
    i = 0;
    while (!(bst === 1'b1 && ssd === 1'b1) && i < 60)
    begin
      go(1);
      i++;
    end
    chk("run reached", 1'b1, bst);
    if (i == 60)
    begin
      err_total++;
      $display("mismatch start timeout expected 1 seen 0");
      summarize();
    end
    go(6);
    chk("sink on", 1'b1, snk);
    chk("flag idle", 1'b0, ff);
    chk("pin released", 1'b1, foe);
  endtask
  task limit_case;
    lim = 1;
    go(1);
    lim = 0;
    chk("boost cut", 1'b0, bst);
    chk("limit no flag", 1'b0, ff | ~dsc);
    go(8);
    chk("boost back", 1'b1, bst);
    fall = 1;
    go(5);
    fall = 0;
    go(2);
    chk("glitch kept on", 1'b1, dsc);
  endtask
  task secondary_case;
    sec = 1;
    go(1);
    sec = 0;
    chk("secondary off", 1'b0, bst | dsc | snk);
    chk("secondary pin", 1'b0, foe | fo);
    en = 0;
    go(30);
    en = 1;
    go(2);
    en = 0;
    go(30);
    chk("latch held", 1'b1, ff);
    go(25);
    chk("latch released", 1'b0, ff);
  endtask
  task overcurrent_case;
    ioc = 1;
    go(1);
    ioc = 0;
    chk("overcurrent off", 1'b0, bst | dsc | snk);
    chk("overcurrent flag", 1'b1, ff);
    rise = 0;
    fall = 1;
    go(10);
    fall = 0;
    chk("uvlo clears", 1'b0, ff | dsc);
  endtask
  task short_case;
    rise = 1;
    go(3);
    en = 0;
    go(1);
    short_req = 6'h20;
    en = 1;
    go(2);
    chk("short flag", 1'b1, ff & dsc);
    chk("short outputs", 1'b0, bst | snk | ssr);
    short_req = 6'h00;
    go(2);
    chk("short cleared", 1'b0, ff);
    ioc = 1;
    go(1);
    ioc = 0;
    chk("startup overcurrent", 1'b0, dsc | ~ff);
  endtask
  initial
  begin
    go(5);
    rstn = 1;
    go(1);
    start_up();
    limit_case();
    secondary_case();
    start_up();
    overcurrent_case();
    short_case();
    summarize();
  end
endmodule
